// ---- hw/sdrd_regs.sv ----
// Configuration bank for initial speed detect and reverse drive.
// Assumes an AXI4-Lite master on CLK_I and a motor algorithm that
// samples the field outputs; decoding of field codes happens there.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module sdrd_regs (
   input  wire logic        CLK_I,
   input  wire logic        RESET_N_I,
   input  wire logic        CE_I,
   input  wire logic [11:0] S_AXI_AWADDR_I,
   input  wire logic        S_AXI_AWVALID_I,
   output logic             S_AXI_AWREADY_O,
   input  wire logic [31:0] S_AXI_WDATA_I,
   input  wire logic [3:0]  S_AXI_WSTRB_I,
   input  wire logic        S_AXI_WVALID_I,
   output logic             S_AXI_WREADY_O,
   output logic [1:0]       S_AXI_BRESP_O,
   output logic             S_AXI_BVALID_O,
   input  wire logic        S_AXI_BREADY_I,
   input  wire logic [11:0] S_AXI_ARADDR_I,
   input  wire logic        S_AXI_ARVALID_I,
   output logic             S_AXI_ARREADY_O,
   output logic [31:0]      S_AXI_RDATA_O,
   output logic [1:0]       S_AXI_RRESP_O,
   output logic             S_AXI_RVALID_O,
   input  wire logic        S_AXI_RREADY_I,
   output logic [3:0]       COAST_DURATION_O,
   output logic [2:0]       STANDSTILL_BACK_EMF_THRESHOLD_O,
   output logic [3:0]       REVERSAL_OPENLOOP_HANDOFF_SPEED_O,
   output logic [1:0]       REVERSAL_OPENLOOP_CURRENT_LIMIT_O,
   output logic [3:0]       REVERSAL_ACCEL_LINEAR_COEFF_O,
   output logic [3:0]       REVERSAL_ACCEL_QUADRATIC_COEFF_O,
   output logic [2:0]       BRAKING_CURRENT_LIMIT_O,
   output logic [9:0]       BRAKING_PROPORTIONAL_GAIN_O,
   output logic [9:0]       BRAKING_INTEGRAL_GAIN_O
);

   // Byte-lane merge, used for both registers
   function automatic logic [31:0] sdrd_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb,
                                             input logic [31:0] mask);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r & mask;
   endfunction : sdrd_merge

   // Low two address bits are ignored; accesses are whole words
   function automatic logic sdrd_hit(input logic [11:0] a,
                                     input logic [11:0] base);
      return a[11:2] == base[11:2];
   endfunction : sdrd_hit

   logic        aw_full_q, aw_full_d;
   logic [11:0] awaddr_q, awaddr_d;
   logic        w_full_q, w_full_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0]  wstrb_q, wstrb_d;
   logic        bvalid_q, bvalid_d;
   logic [1:0]  bresp_q, bresp_d;
   logic        rvalid_q, rvalid_d;
   logic [1:0]  rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] isd_q, isd_d;
   logic [31:0] rev_q, rev_d;
   logic        wr_fire, ar_fire, wr_isd, wr_rev, wr_isd_full, wr_rev_full;
   logic        rev_written_q, rev_written_d;

   // Channel readies drop while frozen so nothing is taken then
   assign S_AXI_AWREADY_O = CE_I & ~aw_full_q;
   assign S_AXI_WREADY_O  = CE_I & ~w_full_q;
   assign S_AXI_ARREADY_O = CE_I & ~rvalid_q;
   assign S_AXI_BVALID_O  = bvalid_q;
   assign S_AXI_BRESP_O   = bresp_q;
   assign S_AXI_RVALID_O  = rvalid_q;
   assign S_AXI_RRESP_O   = rresp_q;
   assign S_AXI_RDATA_O   = rdata_q;

   // Write commits only once address and data are both held
   assign wr_fire = CE_I & aw_full_q & w_full_q & ~bvalid_q;
   assign ar_fire = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
   assign wr_isd  = wr_fire & sdrd_hit(awaddr_q, sdrd_pkg::ISD_ADDR);
   assign wr_rev  = wr_fire & sdrd_hit(awaddr_q, sdrd_pkg::REV_ADDR);

   // Next-state for the bus channels and the two registers
   always_comb begin
      aw_full_d = aw_full_q;
      awaddr_d  = awaddr_q;
      w_full_d  = w_full_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      isd_d     = isd_q;
      rev_d     = rev_q;
      rev_written_d = rev_written_q;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
         aw_full_d = 1'b1;
         awaddr_d  = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
         w_full_d = 1'b1;
         wdata_d  = S_AXI_WDATA_I;
         wstrb_d  = S_AXI_WSTRB_I;
      end
      if (wr_fire) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = (wr_isd | wr_rev) ? sdrd_pkg::RESP_OKAY
                                       : sdrd_pkg::RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY_I) begin
         bvalid_d = 1'b0;
      end
      // Speed-detect low fields: coast, standstill, hand-off, current
      if (wr_isd) begin
         isd_d = sdrd_merge(isd_q, wdata_q, wstrb_q, sdrd_pkg::ISD_MASK);
      end
      // Reverse-drive word is fully writable, reserved bit included
      if (wr_rev) begin
         rev_d = sdrd_merge(rev_q, wdata_q, wstrb_q, sdrd_pkg::REV_MASK);
         rev_written_d = 1'b1;
      end
      if (ar_fire) begin
         rvalid_d = 1'b1;
         rresp_d  = sdrd_pkg::RESP_OKAY;
         if (sdrd_hit(S_AXI_ARADDR_I, sdrd_pkg::ISD_ADDR)) begin
            rdata_d = isd_q;
         end else if (sdrd_hit(S_AXI_ARADDR_I, sdrd_pkg::REV_ADDR)) begin
            rdata_d = rev_q;
         end else begin
            rdata_d = sdrd_pkg::DATA_ZERO;
            rresp_d = sdrd_pkg::RESP_SLVERR;
         end
      end else if (rvalid_q && S_AXI_RREADY_I) begin
         rvalid_d = 1'b0;
      end
   end

   // Registers; clock enable low freezes everything
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         aw_full_q <= 1'b0;
         awaddr_q  <= 12'h000;
         w_full_q  <= 1'b0;
         wdata_q   <= sdrd_pkg::DATA_ZERO;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= sdrd_pkg::RESP_OKAY;
         rvalid_q  <= 1'b0;
         rresp_q   <= sdrd_pkg::RESP_OKAY;
         rdata_q   <= sdrd_pkg::DATA_ZERO;
         isd_q     <= sdrd_pkg::ISD_RESET;
         rev_q     <= sdrd_pkg::REV_RESET;
         rev_written_q <= 1'b0;
      end else if (CE_I) begin
         aw_full_q <= aw_full_d;
         awaddr_q  <= awaddr_d;
         w_full_q  <= w_full_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         isd_q     <= isd_d;
         rev_q     <= rev_d;
         rev_written_q <= rev_written_d;
      end
   end

   // Field outputs straight from the register flops
   assign COAST_DURATION_O =
      isd_q[sdrd_pkg::COAST_LSB +: sdrd_pkg::COAST_W];
   assign STANDSTILL_BACK_EMF_THRESHOLD_O =
      isd_q[sdrd_pkg::BACK_EMF_LSB +: sdrd_pkg::BACK_EMF_W];
   assign REVERSAL_OPENLOOP_HANDOFF_SPEED_O =
      isd_q[sdrd_pkg::HANDOFF_LSB +: sdrd_pkg::HANDOFF_W];
   assign REVERSAL_OPENLOOP_CURRENT_LIMIT_O =
      isd_q[sdrd_pkg::OLCUR_LSB +: sdrd_pkg::OLCUR_W];
   assign REVERSAL_ACCEL_LINEAR_COEFF_O =
      rev_q[sdrd_pkg::ACC1_LSB +: sdrd_pkg::ACC1_W];
   assign REVERSAL_ACCEL_QUADRATIC_COEFF_O =
      rev_q[sdrd_pkg::ACC2_LSB +: sdrd_pkg::ACC2_W];
   // Reserved code 7 is passed through; the algorithm must not use it
   assign BRAKING_CURRENT_LIMIT_O =
      rev_q[sdrd_pkg::BRKCUR_LSB +: sdrd_pkg::BRKCUR_W];
   assign BRAKING_PROPORTIONAL_GAIN_O =
      rev_q[sdrd_pkg::KP_LSB +: sdrd_pkg::KP_W];
   assign BRAKING_INTEGRAL_GAIN_O =
      rev_q[sdrd_pkg::KI_LSB +: sdrd_pkg::KI_W];

   assign wr_isd_full = wr_isd & (&wstrb_q);
   assign wr_rev_full = wr_rev & (&wstrb_q);

   property p_coast;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      wr_isd_full |=> COAST_DURATION_O == $past(wdata_q[12:9]);
   endproperty
   a_coast: assert property (p_coast)
      else $error("coast duration not taken from bits 12-9");

   property p_back_emf;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      wr_isd_full |=> STANDSTILL_BACK_EMF_THRESHOLD_O == $past(wdata_q[8:6]);
   endproperty
   a_back_emf: assert property (p_back_emf)
      else $error("standstill threshold not taken from bits 8-6");

   property p_handoff;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      wr_isd_full |=>
         REVERSAL_OPENLOOP_HANDOFF_SPEED_O == $past(wdata_q[5:2]);
   endproperty
   a_handoff: assert property (p_handoff)
      else $error("hand-off speed not taken from bits 5-2");

   property p_olcur;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (ar_fire && sdrd_hit(S_AXI_ARADDR_I, sdrd_pkg::ISD_ADDR))
         |=> S_AXI_RDATA_O[1:0] == $past(REVERSAL_OPENLOOP_CURRENT_LIMIT_O)
             && S_AXI_RDATA_O[31:13] == 19'h00000;
   endproperty
   a_olcur: assert property (p_olcur)
      else $error("current limit read-back mismatch");

   property p_rev_reset;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      !rev_written_q |-> rev_q == sdrd_pkg::REV_RESET;
   endproperty
   a_rev_reset: assert property (p_rev_reset)
      else $error("reverse-drive word not zero before first write");

   property p_rev_map;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (ar_fire && S_AXI_ARADDR_I == sdrd_pkg::REV_ADDR) |=>
         S_AXI_RVALID_O && S_AXI_RRESP_O == sdrd_pkg::RESP_OKAY
         && S_AXI_RDATA_O == $past(rev_q);
   endproperty
   a_rev_map: assert property (p_rev_map)
      else $error("reverse-drive word not read at its address");

   property p_rsvd;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      wr_rev_full |=> rev_q[31] == $past(wdata_q[31]);
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bit 31 not writable");

   property p_acc1;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      wr_rev_full |=> REVERSAL_ACCEL_LINEAR_COEFF_O == $past(wdata_q[30:27]);
   endproperty
   a_acc1: assert property (p_acc1)
      else $error("linear coefficient not taken from bits 30-27");

   property p_acc2;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      wr_rev_full |=>
         REVERSAL_ACCEL_QUADRATIC_COEFF_O == $past(wdata_q[26:23]);
   endproperty
   a_acc2: assert property (p_acc2)
      else $error("quadratic coefficient not taken from bits 26-23");

   property p_brkcur;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      wr_rev_full |=> BRAKING_CURRENT_LIMIT_O == $past(wdata_q[22:20]);
   endproperty
   a_brkcur: assert property (p_brkcur)
      else $error("brake current limit not taken from bits 22-20");

   property p_gains;
      @(posedge CLK_I) disable iff (!RESET_N_I)
      wr_rev_full |=> BRAKING_PROPORTIONAL_GAIN_O == $past(wdata_q[19:10])
         && BRAKING_INTEGRAL_GAIN_O == $past(wdata_q[9:0]);
   endproperty
   a_gains: assert property (p_gains)
      else $error("braking gains not taken from bits 19-0");
endmodule : sdrd_regs

// ---- include/sdrd_pkg.sv ----
// Package for the speed-detect and reverse-drive configuration bank.
// Assumes a 32-bit AXI4-Lite slave with 12-bit byte addresses.
package sdrd_pkg;
   // Register indices as printed; the byte address is four times the index
   localparam logic [9:0]  ISD_IDX      = 10'h080;
   localparam logic [9:0]  REV_IDX      = 10'h082;
   localparam logic [11:0] ISD_ADDR     = {ISD_IDX, 2'b00};
   localparam logic [11:0] REV_ADDR     = {REV_IDX, 2'b00};
   localparam logic [31:0] ISD_RESET    = 32'h00000000;
   localparam logic [31:0] REV_RESET    = 32'h00000000;
   // Only the low fields of the speed-detect word live in this bank
   localparam logic [31:0] ISD_MASK     = 32'h00001FFF;
   localparam logic [31:0] REV_MASK     = 32'hFFFFFFFF;
   // Speed-detect field positions
   localparam int COAST_LSB   = 9;
   localparam int COAST_W     = 4;
   localparam int BACK_EMF_LSB    = 6;
   localparam int BACK_EMF_W      = 3;
   localparam int HANDOFF_LSB = 2;
   localparam int HANDOFF_W   = 4;
   localparam int OLCUR_LSB   = 0;
   localparam int OLCUR_W     = 2;
   // Reverse-drive field positions
   localparam int RSVD_BIT    = 31;
   localparam int ACC1_LSB    = 27;
   localparam int ACC1_W      = 4;
   localparam int ACC2_LSB    = 23;
   localparam int ACC2_W      = 4;
   localparam int BRKCUR_LSB  = 20;
   localparam int BRKCUR_W    = 3;
   localparam int KP_LSB      = 10;
   localparam int KP_W        = 10;
   localparam int KI_LSB      = 0;
   localparam int KI_W        = 10;
   // Bus responses
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;
   localparam logic [31:0] DATA_ZERO    = 32'h00000000;
endpackage : sdrd_pkg

// ---- test/sdrd_regs_bench.sv ----
// Self-checking bench for the speed-detect and reverse-drive bank.
// Assumes one 50 MHz clock and an AXI4-Lite master modelled here.
`timescale 1ns/1ps
module sdrd_regs_bench;
   localparam logic [1:0]  OK  = sdrd_pkg::RESP_OKAY;
   localparam logic [1:0]  ERR = sdrd_pkg::RESP_SLVERR;
   localparam logic [11:0] ISD = sdrd_pkg::ISD_ADDR;
   localparam logic [11:0] REV = sdrd_pkg::REV_ADDR;
   localparam int          LIMIT = 40;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, olcur;
   logic [31:0] rdata, isd_v, rev_v;
   logic [3:0]  coast, hand, acc1, acc2;
   logic [2:0]  back_emf, bcur;
   logic [9:0]  kp, ki;
   int          mismatches = 0;
   int          comparisons = 0;
   int          c;

   // 20 ns clock
   always #10 clk = ~clk;

   sdrd_regs sdrd_regs_i (
      .CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
      .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready), .COAST_DURATION_O(coast),
      .STANDSTILL_BACK_EMF_THRESHOLD_O(back_emf),
      .REVERSAL_OPENLOOP_HANDOFF_SPEED_O(hand),
      .REVERSAL_OPENLOOP_CURRENT_LIMIT_O(olcur),
      .REVERSAL_ACCEL_LINEAR_COEFF_O(acc1),
      .REVERSAL_ACCEL_QUADRATIC_COEFF_O(acc2),
      .BRAKING_CURRENT_LIMIT_O(bcur),
      .BRAKING_PROPORTIONAL_GAIN_O(kp),
      .BRAKING_INTEGRAL_GAIN_O(ki)
   );

   // Verdict; the only place the run ends
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t resp %h exp %h", $time, got, exp);
      end
   endtask : check_resp

   // A stuck handshake counts as a mismatch and ends the run
   task automatic timed_out;
      mismatches++;
      $display("[ERR] t=%0t wait %h exp %h", $time, 1'b0, 1'b1);
      close_out();
   endtask : timed_out

   // Handshakes are judged at the falling edge, so ready is settled
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                            input logic [3:0] s, input logic [1:0] er);
      int         n;
      logic       ta, tw, got;
      logic [1:0] resp;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      got = 1'b0;
      for (n = 0; n < LIMIT && !got; n++) begin
         @(negedge clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         got = bvalid;
         resp = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (got) bready <= 1'b0;
      end
      if (!got) timed_out();
      check_resp(resp, er);
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a, input logic [31:0] ed,
                           input logic [1:0] er);
      int          n;
      logic        ta, got;
      logic [31:0] d;
      logic [1:0]  resp;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      got = 1'b0;
      for (n = 0; n < LIMIT && !got; n++) begin
         @(negedge clk);
         ta = arvalid & arready;
         got = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (got) rready <= 1'b0;
      end
      if (!got) timed_out();
      check_word(d, ed);
      check_resp(resp, er);
   endtask : axi_read

   // Field outputs against the expected register words
   task automatic check_fields(input logic [31:0] i, input logic [31:0] r);
      check_word({28'h0, coast}, {28'h0, i[12:9]});
      check_word({29'h0, back_emf}, {29'h0, i[8:6]});
      check_word({28'h0, hand}, {28'h0, i[5:2]});
      check_word({30'h0, olcur}, {30'h0, i[1:0]});
      check_word({28'h0, acc1}, {28'h0, r[30:27]});
      check_word({28'h0, acc2}, {28'h0, r[26:23]});
      check_word({29'h0, bcur}, {29'h0, r[22:20]});
      check_word({22'h0, kp}, {22'h0, r[19:10]});
      check_word({22'h0, ki}, {22'h0, r[9:0]});
   endtask : check_fields

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      axi_read(REV, 32'h00000000, OK);
      check_fields(32'h00000000, 32'h00000000);
      // Reserved bit and brake-current code 7 are stored as written
      axi_write(REV, 32'hFFFFFFFF, 4'hF, OK);
      axi_read(REV, 32'hFFFFFFFF, OK);
      check_fields(32'h00000000, 32'hFFFFFFFF);
      // Distinct codes expose swapped or shifted fields
      rev_v = {1'b0, 4'hA, 4'h5, 3'h3, 10'h2AA, 10'h155};
      axi_write(REV, rev_v, 4'hF, OK);
      axi_read(REV, rev_v, OK);
      check_fields(32'h00000000, rev_v);
      // Every code of the speed-detect fields; upper bits are dropped
      for (c = 0; c < 16; c++) begin
         isd_v = {19'h7FFFF, c[3:0], c[2:0], ~c[3:0], c[1:0]};
         axi_write(ISD, isd_v, 4'hF, OK);
         axi_read(ISD, isd_v & sdrd_pkg::ISD_MASK, OK);
         check_fields(isd_v, rev_v);
      end
      // Only byte lane 0 of the integral gain is written
      axi_write(REV, 32'h00000000, 4'h1, OK);
      rev_v = rev_v & 32'hFFFFFF00;
      axi_read(REV, rev_v, OK);
      // Unmapped word between the two registers changes nothing
      axi_write(12'h204, 32'hFFFFFFFF, 4'hF, ERR);
      axi_read(12'h204, sdrd_pkg::DATA_ZERO, ERR);
      axi_read(REV, rev_v, OK);
      check_fields(isd_v, rev_v);
      // Clock enable low holds off new addresses
      @(posedge clk);
      ce <= 1'b0;
      @(negedge clk);
      check_word({29'h0, awready, wready, arready}, 32'h00000000);
      @(posedge clk);
      ce <= 1'b1;
      // A second reset in mid-run restores zeros
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      axi_read(REV, 32'h00000000, OK);
      check_fields(32'h00000000, 32'h00000000);
      close_out();
   end
endmodule : sdrd_regs_bench
